// ---- dca_ccm_end.sv ----
// Control channel master and transmit channel selector end.
// Assumes the controller end keeps control memory blocked for arbitrated
// channels and holds the broadcast group steady during a frame.
//
// Overview of operation
// [R1] Master works in any clock mode; enables decide
// [R2] Enabled and available: force MR 1 or x0xx
// [R3] Enabled but blocked: pass control memory value
// [R4] Software loads control memory with blocked code
// [R5] Disabled channel: always pass control memory value
// [R6] Master off: enabled channels sent available
// [R7] Full selection: enabled channels available, immediately
// [R8] Expect/receive: only addressed channel may be available
// [R9] Master on, machine suspended: pass control memory
// [R10] Downstream: no arbitration, frames kept in order
// [R11] Software sets destination before each frame command
// [R12] Frame goes to one channel or broadcast group
// [R13] Back-to-back frames to different channels, no gaps
// [R14] Broadcast group not changed during a frame
// [R15] Limited selection blocks the last received terminal
// [R16] Full-selection count exceeds loop delay
// [R17] Suspend count 0 or 1 by transceiver type
`timescale 1ns/1ns
`default_nettype none
module dca_ccm_end
  import dca_pkg::*;
(
  input  wire logic                    clock,     // 125 MHz clock
  input  wire logic                    rst,       // Synchronous reset
  dca_link_if.dev                      lnk,       // Link from controller end
  output logic                         cc_valid,  // Control slot out valid
  output logic [dca_pkg::CHW-1:0]      cc_slot,   // Channel of the slot
  output logic [dca_pkg::CIW-1:0]      cc_ci,     // C/I code sent
  output logic                         cc_mr,     // MR bit sent
  output logic                         cc_avail,  // Slot overridden to available
  output logic                         dch_valid, // D-channel bit valid
  output logic                         dch_bit,   // D-channel bit
  output logic [dca_pkg::NCH-1:0]      dch_mask,  // Channels carrying the bit
  output logic                         tx_active  // Frame in progress
);
  import dca_pkg::*;

  // ************************************************************
  // Upstream control channel
  // ************************************************************
  logic             ccv_r,   ccv_nxt;
  logic [CHW-1:0]   ccs_r,   ccs_nxt;
  logic [CIW-1:0]   cci_r,   cci_nxt;
  logic             ccm_r,   ccm_nxt;
  logic             cca_r,   cca_nxt;
  logic             en_hit;
  logic             arb_av;
  logic             force_av;

  always_comb
  begin
    en_hit   = dca_chan_hit(lnk.chan_en, lnk.slot_idx);
    arb_av   = 1'b0;
    force_av = 1'b0;
    // Arbiter view of availability for this slot
    case (lnk.asm_state)
      DCA_FULL:
      begin
        arb_av = 1'b1;                                           // [R7]
      end
      DCA_LIMIT:
      begin
        arb_av = dca_chan_hit(lnk.chan_sh, lnk.slot_idx);        // [R15]
      end
      DCA_EXPECT, DCA_RECV:
      begin
        arb_av = (lnk.slot_idx == lnk.asm_chan);                 // [R8]
      end
      default:
      begin
        arb_av = 1'b0;
      end
    endcase
    if (!lnk.master_en)
    begin
      force_av = en_hit;                                         // [R6]
    end
    else if (lnk.asm_state == DCA_SUSP)
    begin
      force_av = 1'b0;                                           // [R9]
    end
    else
    begin
      force_av = en_hit & arb_av;                                // [R1] [R5]
    end
    ccv_nxt = lnk.slot_valid;
    ccs_nxt = lnk.slot_idx;
    cca_nxt = lnk.slot_valid & force_av;
    cci_nxt = lnk.slot_ci;                                       // [R3]
    ccm_nxt = lnk.slot_mr;                                       // [R3]
    if (force_av)
    begin
      if (lnk.cc_sel)
      begin
        ccm_nxt = 1'b1;                                          // [R2]
      end
      else
      begin
        cci_nxt[CI_AVBIT] = 1'b0;                                // [R2]
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ccv_r <= 1'b0;
      ccs_r <= 5'h00;
      cci_r <= 4'h0;
      ccm_r <= 1'b0;
      cca_r <= 1'b0;
    end
    else
    begin
      ccv_r <= ccv_nxt;
      ccs_r <= ccs_nxt;
      cci_r <= cci_nxt;
      ccm_r <= ccm_nxt;
      cca_r <= cca_nxt;
    end
  end

  // ************************************************************
  // Downstream transmit channel selection
  // ************************************************************
  dca_tx_t          tst_r,   tst_nxt;
  logic [NCH-1:0]   fmask_r, fmask_nxt;
  logic [NCH-1:0]   dm_r,    dm_nxt;
  logic             dv_r,    dv_nxt;
  logic             db_r,    db_nxt;
  logic [NCH-1:0]   new_mask;

  always_comb
  begin
    new_mask  = '0;
    if (lnk.tx_dest[DST_BCAST])
    begin
      new_mask = lnk.bcast_grp;                                  // [R12]
    end
    else
    begin
      new_mask[lnk.tx_dest[CHW-1:0]] = 1'b1;                     // [R12]
    end
    tst_nxt   = tst_r;
    fmask_nxt = fmask_r;
    case (tst_r)
      DCA_TX_IDLE:
      begin
        if (lnk.tx_valid && lnk.tx_sof)
        begin
          tst_nxt   = DCA_TX_SEND;
          fmask_nxt = new_mask;
        end
      end
      DCA_TX_SEND:
      begin
        if (lnk.tx_valid && lnk.tx_sof)
        begin
          fmask_nxt = new_mask;                                  // [R13]
        end
        else if (!lnk.tx_valid)
        begin
          tst_nxt = DCA_TX_IDLE;
        end
      end
      default:
      begin
        tst_nxt = DCA_TX_IDLE;
      end
    endcase
    // Bits pass in arrival order, no reordering
    dv_nxt = lnk.tx_valid;                                       // [R10]
    db_nxt = lnk.tx_bit;
    if (!lnk.tx_valid)
    begin
      dm_nxt = '0;
    end
    else if (lnk.tx_sof)
    begin
      dm_nxt = new_mask;                                         // [R13]
    end
    else
    begin
      dm_nxt = fmask_r;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tst_r   <= DCA_TX_IDLE;
      fmask_r <= 32'h0000_0000;
      dm_r    <= 32'h0000_0000;
      dv_r    <= 1'b0;
      db_r    <= 1'b0;
    end
    else
    begin
      tst_r   <= tst_nxt;
      fmask_r <= fmask_nxt;
      dm_r    <= dm_nxt;
      dv_r    <= dv_nxt;
      db_r    <= db_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign cc_valid  = ccv_r;
  assign cc_slot   = ccs_r;
  assign cc_ci     = cci_r;
  assign cc_mr     = ccm_r;
  assign cc_avail  = cca_r;
  assign dch_valid = dv_r;
  assign dch_bit   = db_r;
  assign dch_mask  = dm_r;
  assign tx_active = (tst_r == DCA_TX_SEND);

endmodule // dca_ccm_end
`default_nettype wire

// ---- dca_ctl_end.sv ----
// Controller end: software registers, control memory scan and frame feed.
// Assumes the HDLC source gives one bit per cycle with a start-of-frame mark.
`timescale 1ns/1ns
`default_nettype none
module dca_ctl_end
  import dca_pkg::*;
(
  input  wire logic                 clock,      // 125 MHz clock
  input  wire logic                 rst,        // Synchronous reset
  input  wire logic [dca_pkg::AW-1:0] addr,     // Register address
  input  wire logic [dca_pkg::DW-1:0] wdata,    // Write data
  input  wire logic                 wr,         // Write strobe
  input  wire logic                 rd,         // Read strobe
  output logic      [dca_pkg::DW-1:0] rdata,    // Read data, cycle after rd
  input  wire logic                 hdlc_valid, // HDLC bit valid
  input  wire logic                 hdlc_sof,   // First bit of a frame
  input  wire logic                 hdlc_bit,   // HDLC bit
  input  wire logic                 hdlc_busy,  // Frame in transmission
  dca_link_if.ctl                   lnk         // Link to control master
);
  import dca_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [1:0]       ctrl_r,  ctrl_nxt;
  logic [NCH-1:0]   en_r,    en_nxt;
  logic [NCH-1:0]   sh_r,    sh_nxt;
  logic [7:0]       st_r,    st_nxt;
  logic [5:0]       dest_r,  dest_nxt;
  logic [5:0]       cdest_r, cdest_nxt;
  logic [NCH-1:0]   bcg_r,   bcg_nxt;
  logic [CIW:0]     cm_r [NCH];
  logic [CIW:0]     cm_nxt [NCH];
  logic [CHW-1:0]   slot_r,  slot_nxt;
  logic [DW-1:0]    rdata_r, rdata_nxt;
  logic             txv_r, txs_r, txb_r;
  logic             sv_r;
  logic [CIW:0]     sw_r;
  logic [CHW-1:0]   si_r;
  logic [CHW-1:0]   cidx;

  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    en_nxt    = en_r;
    sh_nxt    = sh_r;
    st_nxt    = st_r;
    dest_nxt  = dest_r;
    cdest_nxt = cdest_r;
    bcg_nxt   = bcg_r;
    cm_nxt    = cm_r;
    cidx      = addr[CHW+1:2];
    slot_nxt  = slot_r + 5'h01;
    rdata_nxt = 32'h0000_0000;
    if (wr)
    begin
      case (addr)
        OFS_CTRL:   ctrl_nxt = wdata[1:0];
        OFS_ENABLE: en_nxt   = wdata;
        OFS_SHADOW: sh_nxt   = wdata;
        OFS_STATE:  st_nxt   = wdata[7:0];
        OFS_DEST:   dest_nxt = wdata[5:0];
        OFS_BCAST:  if (!hdlc_busy) bcg_nxt = wdata;  // [R14]
        OFS_CMD:    cdest_nxt = dest_r;               // [R11]
        default:    if (addr >= OFS_CMEM) cm_nxt[cidx] = wdata[CIW:0];  // [R4]
      endcase
    end
    if (rd)
    begin
      case (addr)
        OFS_CTRL:   rdata_nxt = {30'h0, ctrl_r};
        OFS_ENABLE: rdata_nxt = en_r;
        OFS_SHADOW: rdata_nxt = sh_r;
        OFS_STATE:  rdata_nxt = {24'h0, st_r};
        OFS_DEST:   rdata_nxt = {26'h0, dest_r};
        OFS_BCAST:  rdata_nxt = bcg_r;
        OFS_STATUS: rdata_nxt = {31'h0, hdlc_busy};
        default:    if (addr >= OFS_CMEM) rdata_nxt = {27'h0, cm_r[cidx]};
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_r  <= RST_CTRL;
      en_r    <= RST_EN;
      sh_r    <= RST_EN;
      st_r    <= {RST_STATE, 5'h00};
      dest_r  <= 6'h00;
      cdest_r <= 6'h00;
      bcg_r   <= RST_EN;
      for (int i = 0; i < NCH; i++) cm_r[i] <= RST_CMEM;
      slot_r  <= 5'h00;
      rdata_r <= 32'h0000_0000;
      txv_r   <= 1'b0;
      txs_r   <= 1'b0;
      txb_r   <= 1'b0;
      sv_r    <= 1'b0;
      sw_r    <= RST_CMEM;
      si_r    <= 5'h00;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      en_r    <= en_nxt;
      sh_r    <= sh_nxt;
      st_r    <= st_nxt;
      dest_r  <= dest_nxt;
      cdest_r <= cdest_nxt;
      bcg_r   <= bcg_nxt;
      cm_r    <= cm_nxt;
      slot_r  <= slot_nxt;
      rdata_r <= rdata_nxt;
      txv_r   <= hdlc_valid;
      txs_r   <= hdlc_valid & hdlc_sof;
      txb_r   <= hdlc_bit;
      sv_r    <= 1'b1;
      sw_r    <= cm_r[slot_r];
      si_r    <= slot_r;
    end
  end

  // ************************************************************
  // Link drive
  // ************************************************************
  assign rdata          = rdata_r;
  assign lnk.master_en  = ctrl_r[CTRL_MEN];
  assign lnk.cc_sel     = ctrl_r[CTRL_SEL];
  assign lnk.chan_en    = en_r;
  assign lnk.chan_sh    = sh_r;
  assign lnk.asm_state  = dca_state_decode(st_r[ST_CODE+:3]);
  assign lnk.asm_chan   = st_r[ST_CHAN+:CHW];
  assign lnk.slot_valid = sv_r;
  assign lnk.slot_idx   = si_r;
  assign lnk.slot_ci    = sw_r[CIW-1:0];
  assign lnk.slot_mr    = sw_r[CM_MR];
  assign lnk.tx_valid   = txv_r;
  assign lnk.tx_sof     = txs_r;
  assign lnk.tx_bit     = txb_r;
  assign lnk.tx_dest    = cdest_r;
  assign lnk.bcast_grp  = bcg_r;

endmodule // dca_ctl_end
`default_nettype wire

// ---- dca_link_checker.sv ----
// Checker on the link between the two ends and on the device end outputs.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/1ns
`default_nettype none
module dca_link_checker
  import dca_pkg::*;
(
  input wire logic                    clock,      // Clock
  input wire logic                    rst,        // Reset
  input wire logic                    master_en,  // Link
  input wire logic                    cc_sel,     // Link
  input wire logic [dca_pkg::NCH-1:0] chan_en,    // Link
  input wire logic [dca_pkg::NCH-1:0] chan_sh,    // Link
  input wire dca_pkg::dca_asm_t       asm_state,  // Link
  input wire logic [dca_pkg::CHW-1:0] asm_chan,   // Link
  input wire logic                    slot_valid, // Link
  input wire logic [dca_pkg::CHW-1:0] slot_idx,   // Link
  input wire logic [dca_pkg::CIW-1:0] slot_ci,    // Link
  input wire logic                    slot_mr,    // Link
  input wire logic                    tx_valid,   // Link
  input wire logic                    tx_sof,     // Link
  input wire logic                    tx_bit,     // Link
  input wire logic [dca_pkg::DST_BCAST:0] tx_dest, // Link
  input wire logic [dca_pkg::NCH-1:0] bcast_grp,  // Link
  input wire logic [dca_pkg::CHW-1:0] cc_slot,    // Device out
  input wire logic [dca_pkg::CIW-1:0] cc_ci,      // Device out
  input wire logic                    cc_mr,      // Device out
  input wire logic                    cc_avail,   // Device out
  input wire logic                    dch_valid,  // Device out
  input wire logic                    dch_bit,    // Device out
  input wire logic [dca_pkg::NCH-1:0] dch_mask    // Device out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence frame_go_s;
    tx_valid && tx_sof ##1 tx_valid && !tx_sof;
  endsequence

  master_off_a:
    assert property (slot_valid && !master_en && chan_en[slot_idx] |=>
      cc_avail && cc_slot == $past(slot_idx)) else $error("enabled slot not available");
  mr_path_a:
    assert property (slot_valid && cc_sel |=>
      (cc_avail ? cc_mr : cc_mr == $past(slot_mr))) else $error("bad MR value");
  ci_path_a:
    assert property (slot_valid && !cc_sel |=>
      cc_ci == (cc_avail ? ($past(slot_ci) & 4'hB) : $past(slot_ci)))
      else $error("bad C/I value");
  disabled_pass_a:
    assert property (slot_valid && !chan_en[slot_idx] |=> !cc_avail)
      else $error("disabled slot overridden");
  susp_pass_a:
    assert property (slot_valid && master_en && asm_state == DCA_SUSP |=> !cc_avail)
      else $error("slot overridden while suspended");
  full_sel_a:
    assert property (slot_valid && master_en && asm_state == DCA_FULL |=>
      cc_avail == $past(chan_en[slot_idx])) else $error("full selection wrong");
  expect_sel_a:
    assert property (slot_valid && master_en && (asm_state == DCA_EXPECT ||
      asm_state == DCA_RECV) |=> cc_avail == $past(chan_en[slot_idx] && slot_idx == asm_chan))
      else $error("expect or receive selection wrong");
  limited_sel_a:
    assert property (slot_valid && master_en && asm_state == DCA_LIMIT |=>
      cc_avail == $past(chan_en[slot_idx] && chan_sh[slot_idx]))
      else $error("limited selection wrong");
  chan_mask_a:
    assert property (tx_valid && tx_sof && !tx_dest[DST_BCAST] |=> dch_valid &&
      dch_mask == (32'h0000_0001 << $past(tx_dest[4:0]))) else $error("bad channel mask");
  bcast_mask_a:
    assert property (tx_valid && tx_sof && tx_dest[DST_BCAST] |=>
      dch_mask == $past(bcast_grp)) else $error("bad broadcast mask");
  mask_hold_a:
    assert property (frame_go_s |=> $stable(dch_mask)) else $error("mask moved in frame");
  bit_order_a:
    assert property (tx_valid |=> dch_valid && dch_bit == $past(tx_bit))
      else $error("bit lost or reordered");
  idle_line_a:
    assert property (!tx_valid |=> !dch_valid && dch_mask == 32'h0000_0000)
      else $error("line not idle");
endmodule // dca_link_checker
`default_nettype wire

// ---- dca_link_if.sv ----
// Link between the arbiter controller end and the control master / selector end.
// Assumes both ends share the clock that drives the controller end registers.
`timescale 1ns/1ns
`default_nettype none
interface dca_link_if;
  import dca_pkg::*;

  logic                   master_en;    // master_enable_bit
  logic                   cc_sel;       // control_channel_select
  logic [NCH-1:0]         chan_en;      // channel_enable_regs
  logic [NCH-1:0]         chan_sh;      // channel_enable_shadow
  dca_asm_t               asm_state;    // arbitration_state_machine state
  logic [CHW-1:0]         asm_chan;     // arbiter_state_reg channel field
  logic                   slot_valid;   // Control memory slot strobe
  logic [CHW-1:0]         slot_idx;     // Channel of this slot
  logic [CIW-1:0]         slot_ci;      // Control memory C/I
  logic                   slot_mr;      // Control memory MR
  logic                   tx_valid;     // HDLC bit valid
  logic                   tx_sof;       // First bit of a frame
  logic                   tx_bit;       // HDLC bit
  logic [DST_BCAST:0]     tx_dest;      // transmit_dest_address of the frame
  logic [NCH-1:0]         bcast_grp;    // broadcast_group_regs

  modport dev (
    input master_en, cc_sel, chan_en, chan_sh, asm_state, asm_chan,
    input slot_valid, slot_idx, slot_ci, slot_mr,
    input tx_valid, tx_sof, tx_bit, tx_dest, bcast_grp
  );
  modport ctl (
    output master_en, cc_sel, chan_en, chan_sh, asm_state, asm_chan,
    output slot_valid, slot_idx, slot_ci, slot_mr,
    output tx_valid, tx_sof, tx_bit, tx_dest, bcast_grp
  );
endinterface
`default_nettype wire

// ---- dca_pkg.sv ----
// Shared constants and types of the D-channel control master and transmit selector.
// Assumes one 125 MHz clock and a synchronous active-high reset in both ends.
package dca_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int NCH       = 32;
  localparam int CHW       = 5;
  localparam int CIW       = 4;
  localparam int DW        = 32;
  localparam int AW        = 8;
  localparam int CI_AVBIT  = 2;       // Position of the 0/1 in x0xx / x1xx
  localparam int DST_BCAST = 5;       // Destination field: broadcast flag

  // ************************************************************
  // Control register offsets (byte addresses)
  // ************************************************************
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_ENABLE = 8'h04;
  localparam logic [AW-1:0] OFS_SHADOW = 8'h08;
  localparam logic [AW-1:0] OFS_STATE  = 8'h0C;
  localparam logic [AW-1:0] OFS_DEST   = 8'h10;
  localparam logic [AW-1:0] OFS_BCAST  = 8'h14;
  localparam logic [AW-1:0] OFS_CMD    = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS = 8'h1C;
  localparam logic [AW-1:0] OFS_CMEM   = 8'h80;  // 32 words, one per channel

  // Field positions
  localparam int CTRL_MEN  = 0;       // master_enable_bit
  localparam int CTRL_SEL  = 1;       // control_channel_select, 1 = MR
  localparam int ST_CHAN   = 0;       // arbiter_state_reg channel, 5 bits
  localparam int ST_CODE   = 5;       // arbiter_state_reg state, 3 bits
  localparam int CM_MR     = 4;       // Control memory word: MR in bit 4, C/I in 3:0

  // Reset values
  localparam logic [1:0]     RST_CTRL  = 2'h0;
  localparam logic [NCH-1:0] RST_EN    = 32'h0000_0000;
  localparam logic [2:0]     RST_STATE = 3'h0;
  localparam logic [CIW:0]   RST_CMEM  = 5'h04;  // Blocked C/I, MR 0

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    DCA_SUSP   = 5'h01,
    DCA_FULL   = 5'h02,
    DCA_EXPECT = 5'h04,
    DCA_RECV   = 5'h08,
    DCA_LIMIT  = 5'h10
  } dca_asm_t;

  typedef enum logic [1:0] {
    DCA_TX_IDLE = 2'h1,
    DCA_TX_SEND = 2'h2
  } dca_tx_t;

  // State code 0..4 as in arbiter_state_reg bits 7:5
  function automatic dca_asm_t dca_state_decode(input logic [2:0] code);
    case (code)
      3'h1:    return DCA_FULL;
      3'h2:    return DCA_EXPECT;
      3'h3:    return DCA_RECV;
      3'h4:    return DCA_LIMIT;
      default: return DCA_SUSP;
    endcase
  endfunction

  function automatic logic dca_chan_hit(input logic [NCH-1:0] v, input logic [CHW-1:0] i);
    return v[i];
  endfunction

endpackage

// ---- dchannel_control_and_tx_select_test.sv ----
// Testbench joining the controller end and the device end over the link.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module dchannel_control_and_tx_select_test;
  import dca_pkg::*;
  typedef struct packed {
    logic       men, sel, en, sh;
    logic [2:0] code;
    logic [4:0] achan;
    logic [4:0] mem;
    logic       av;
    logic [3:0] out;
  } dca_row_t;
  logic           clock, rst, wr, rd, hdlc_valid, hdlc_sof, hdlc_bit, hdlc_busy;
  logic [AW-1:0]  addr;
  logic [DW-1:0]  wdata, rdata, got;
  logic           cc_valid, cc_mr, cc_avail, dch_valid, dch_bit, tx_active;
  logic [CHW-1:0] cc_slot;
  logic [CIW-1:0] cc_ci;
  logic [NCH-1:0] dch_mask;
  logic [15:0]    pat;
  logic [32:0]    seen[$], want[$];
  dca_row_t       rows[11];
  int             fail_count, n_compared, n;

  dca_link_if dca_link_if_i ();
  dca_ctl_end dca_ctl_end_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .hdlc_valid(hdlc_valid), .hdlc_sof(hdlc_sof),
    .hdlc_bit(hdlc_bit), .hdlc_busy(hdlc_busy), .lnk(dca_link_if_i));
  dca_ccm_end dca_ccm_end_i (.clock(clock), .rst(rst), .lnk(dca_link_if_i),
    .cc_valid(cc_valid), .cc_slot(cc_slot), .cc_ci(cc_ci), .cc_mr(cc_mr),
    .cc_avail(cc_avail), .dch_valid(dch_valid), .dch_bit(dch_bit), .dch_mask(dch_mask),
    .tx_active(tx_active));
  dca_link_checker dca_link_checker_i (.clock(clock), .rst(rst),
    .master_en(dca_link_if_i.master_en), .cc_sel(dca_link_if_i.cc_sel),
    .chan_en(dca_link_if_i.chan_en), .chan_sh(dca_link_if_i.chan_sh),
    .asm_state(dca_link_if_i.asm_state), .asm_chan(dca_link_if_i.asm_chan),
    .slot_valid(dca_link_if_i.slot_valid), .slot_idx(dca_link_if_i.slot_idx),
    .slot_ci(dca_link_if_i.slot_ci), .slot_mr(dca_link_if_i.slot_mr),
    .tx_valid(dca_link_if_i.tx_valid), .tx_sof(dca_link_if_i.tx_sof),
    .tx_bit(dca_link_if_i.tx_bit), .tx_dest(dca_link_if_i.tx_dest),
    .bcast_grp(dca_link_if_i.bcast_grp), .cc_slot(cc_slot), .cc_ci(cc_ci), .cc_mr(cc_mr),
    .cc_avail(cc_avail), .dch_valid(dch_valid), .dch_bit(dch_bit), .dch_mask(dch_mask));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check_word(input logic [DW-1:0] g, input logic [DW-1:0] e, input string w);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask
  task automatic check_bit(input logic g, input logic e, input string w);
    check_word({31'h0, g}, {31'h0, e}, w);
  endtask
  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr    <= 1'h0;
  endtask
  task automatic bus_rd(input logic [AW-1:0] a);
    @(posedge clock);
    rd   <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd   <= 1'h0;
    @(negedge clock);
    got = rdata;
  endtask
  task automatic wait_slot3;
    n = 0;
    @(negedge clock);
    while (!(cc_valid === 1'h1 && cc_slot === 5'h03) && n < 64)
    begin
      @(negedge clock);
      n++;
    end
    check_bit(n < 64, 1'h1, "slot 3 seen");
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(negedge clock)
    if (dch_valid === 1'h1)
      seen.push_back({dch_mask, dch_bit});

  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog ran out", $time);
    test_done();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    rst = 1'h1;
    {wr, rd, hdlc_valid, hdlc_sof, hdlc_bit, hdlc_busy} = 6'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    pat = 16'hB26D;
    rows = '{'{1'h0, 1'h0, 1'h1, 1'h0, 3'h0, 5'h00, 5'h04, 1'h1, 4'h0},
             '{1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 5'h00, 5'h04, 1'h1, 4'h1},
             '{1'h0, 1'h0, 1'h0, 1'h0, 3'h0, 5'h00, 5'h0F, 1'h0, 4'hF},
             '{1'h1, 1'h0, 1'h1, 1'h0, 3'h0, 5'h00, 5'h0E, 1'h0, 4'hE},
             '{1'h1, 1'h0, 1'h1, 1'h0, 3'h1, 5'h00, 5'h0F, 1'h1, 4'hB},
             '{1'h1, 1'h1, 1'h0, 1'h0, 3'h1, 5'h00, 5'h10, 1'h0, 4'h1},
             '{1'h1, 1'h0, 1'h1, 1'h1, 3'h4, 5'h00, 5'h06, 1'h1, 4'h2},
             '{1'h1, 1'h0, 1'h1, 1'h0, 3'h4, 5'h00, 5'h04, 1'h0, 4'h4},
             '{1'h1, 1'h1, 1'h1, 1'h0, 3'h2, 5'h03, 5'h00, 1'h1, 4'h1},
             '{1'h1, 1'h1, 1'h1, 1'h0, 3'h3, 5'h05, 5'h00, 1'h0, 4'h0},
             '{1'h1, 1'h0, 1'h1, 1'h0, 3'h5, 5'h00, 5'h0C, 1'h0, 4'hC}};
    repeat (9) @(posedge clock);
    @(negedge clock);
    check_bit(cc_valid, 1'h0, "cc_valid in reset");
    check_bit(dch_valid, 1'h0, "dch_valid in reset");
    @(posedge clock);
    rst <= 1'h0;
    bus_rd(OFS_CTRL);
    check_word(got, 32'h0000_0000, "ctrl reset");
    bus_rd(OFS_STATE);
    check_word(got, 32'h0000_0000, "state reset");
    bus_rd(OFS_CMEM);
    check_word(got, 32'h0000_0004, "memory reset");
    bus_rd(8'h40);
    check_word(got, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    foreach (rows[i])
    begin
      bus_wr(OFS_CTRL, {30'h0, rows[i].sel, rows[i].men});
      bus_wr(OFS_ENABLE, {28'h0, rows[i].en, 3'h0});
      bus_wr(OFS_SHADOW, {28'h0, rows[i].sh, 3'h0});
      bus_wr(OFS_STATE, {24'h0, rows[i].code, rows[i].achan});
      bus_wr(OFS_CMEM + 8'h0C, {27'h0, rows[i].mem});
      repeat (4) @(posedge clock);
      wait_slot3();
      check_bit(cc_avail, rows[i].av, "available");
      if (rows[i].sel)
        check_bit(cc_mr, rows[i].out[0], "mr");
      else
        check_word({28'h0, cc_ci}, {28'h0, rows[i].out}, "ci");
    end
    $display("test control slots done");
    bus_wr(OFS_BCAST, 32'hA5A5_0001);
    bus_wr(OFS_DEST, 32'h0000_0003);
    bus_wr(OFS_CMD, 32'h0000_0001);
    hdlc_busy <= 1'h1;
    seen.delete();
    fork
      for (int b = 0; b < 16; b++)
      begin
        @(posedge clock);
        hdlc_valid <= 1'h1;
        hdlc_sof   <= (b == 0 || b == 8);
        hdlc_bit   <= pat[15-b];
        want.push_back({(b < 8) ? 32'h0000_0008 : 32'hA5A5_0001, pat[15-b]});
      end
      begin
        repeat (2) @(posedge clock);
        bus_wr(OFS_DEST, 32'h0000_0020);
        bus_wr(OFS_CMD, 32'h0000_0001);
      end
    join
    @(negedge clock);
    check_bit(tx_active, 1'h1, "frame active");
    @(posedge clock);
    hdlc_valid <= 1'h0;
    hdlc_sof   <= 1'h0;
    repeat (4) @(posedge clock);
    check_word(seen.size(), 32'h0000_0010, "bits out");
    check_bit(tx_active, 1'h0, "frame ended");
    foreach (want[i])
    begin
      check_word(seen[i][32:1], want[i][32:1], "mask");
      check_bit(seen[i][0], want[i][0], "bit");
    end
    bus_wr(OFS_BCAST, 32'hFFFF_FFFF);
    bus_rd(OFS_BCAST);
    check_word(got, 32'hA5A5_0001, "group kept");
    $display("test transmit done");
    @(posedge clock);
    hdlc_busy <= 1'h0;
    rst       <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    @(negedge clock);
    check_bit(cc_valid, 1'h0, "cc_valid after reset");
    check_bit(tx_active, 1'h0, "tx_active after reset");
    bus_rd(OFS_BCAST);
    check_word(got, 32'h0000_0000, "group reset");
    $display("test second reset done");
    test_done();
  end
endmodule // dchannel_control_and_tx_select_test
`default_nettype wire
